/* iam_core.v */
// Slave address recognition and SMBus timeout monitor of a two-wire controller.
`include "iam_defs.vh"
`default_nettype none
module iam_core #(
  parameter integer TLOW_CYC = `IAM_TLOW_CYC,
  parameter integer THIGH_CYC = `IAM_THIGH_CYC,
  parameter integer MASTER_EXTEND_TIMEOUT_CYC = `IAM_MASTER_EXTEND_TIMEOUT_CYC,
  parameter integer SLAVE_EXTEND_TIMEOUT_CYC = `IAM_SLAVE_EXTEND_TIMEOUT_CYC,
  parameter integer CW = 22
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Bus pins
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Configuration
  input wire module_enable,
  input wire [6:0] primary_address,
  input wire [2:0] upper_address,
  input wire address_extension_enable,
  input wire general_call_enable,
  input wire alert_response_enable,
  input wire second_address_enable,
  input wire [6:0] second_address,
  input wire range_match_enable,
  input wire [6:0] range_address,
  input wire fast_ack_enable,
  input wire transmit_ack_select,
  input wire ack_release,
  input wire [CW-1:0] data_low_limit,
  input wire master_active,
  input wire master_extending,
  input wire [7:0] transmit_data,
  // Status
  output reg addressed_as_slave_flag,
  output reg slave_transmit,
  output reg transfer_complete_flag,
  output reg data_invalid,
  output reg [7:0] receive_data,
  output reg bus_busy,
  output reg bus_high_timeout_flag,
  output reg data_low_timeout_flag,
  output reg clock_low_timeout_flag,
  output reg master_extend_timeout,
  output reg slave_extend_timeout,
  output reg common_interrupt_flag,
  output reg master_stop_request,
  input wire flag_clear
);
  // ********************
  // Line sampling
  // ********************
  wire scl_q, sda_q, scl_rise, scl_fall, sda_rise, sda_fall;
  iam_sync u_scl (.clock(clock), .nrst(nrst), .line_in(scl_in), .line_q(scl_q), .rise(scl_rise), .fall(scl_fall));
  iam_sync u_sda (.clock(clock), .nrst(nrst), .line_in(sda_in), .line_q(sda_q), .rise(sda_rise), .fall(sda_fall));
  wire start_det = sda_fall & scl_q;
  wire stop_det = sda_rise & scl_q;

  // ********************
  // Slave sequencer
  // ********************
  localparam [2:0] ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ADDR2 = 3'h2, ST_RX = 3'h3, ST_TX = 3'h4;
  reg [2:0] state_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg ack_q, ten_sel_q, hold_q, tx_nack_q;
  reg [CW-1:0] low_cnt_q, high_cnt_q, dlow_cnt_q, master_extend_timeout_cnt_q, slave_extend_timeout_cnt_q;
  reg slt_hold_q;
  wire [7:0] byte_in = shift_q;
  wire slt_event = (low_cnt_q == TLOW_CYC[CW-1:0] - 1'b1) & ~scl_q;
  wire byte_edge = scl_fall & (bit_q == 4'h8);
  wire dlow_hit = scl_q & ~sda_q & (data_low_limit != {CW{1'b0}}) & (dlow_cnt_q == data_low_limit - 1'b1);
  wire master_extend_timeout_hit = (master_extend_timeout_cnt_q == MASTER_EXTEND_TIMEOUT_CYC[CW-1:0]) & ~master_extend_timeout;
  wire slave_extend_timeout_hit = (slave_extend_timeout_cnt_q == SLAVE_EXTEND_TIMEOUT_CYC[CW-1:0]) & ~slave_extend_timeout;

  // Seven-bit compare of the incoming byte.
  wire [6:0] a7 = byte_in[7:1];
  wire m_prim = (a7 == primary_address) & ~address_extension_enable;
  wire m_gc = general_call_enable & (a7 == `IAM_GENERAL_CALL);
  wire m_al = alert_response_enable & (a7 == `IAM_ALERT_RESPONSE);
  wire m_sec = second_address_enable & (a7 == second_address);
  wire m_rng_self = (range_address != 7'h00) & (a7 == range_address);
  wire m_rng = range_match_enable & (a7 > primary_address) & (a7 < range_address);
  wire m7 = (m_prim | m_gc | m_al | m_sec | m_rng_self | m_rng) & ~byte_in[0];
  wire hdr = (byte_in[7:3] == `IAM_TENBIT_HDR) & address_extension_enable;
  wire hdr_match = hdr & (byte_in[2:1] == upper_address[2:1]);
  wire low_match = (byte_in == {upper_address[0], primary_address});

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
      ten_sel_q <= 1'b0;
      hold_q <= 1'b0;
      tx_nack_q <= 1'b0;
      addressed_as_slave_flag <= 1'b0;
      slave_transmit <= 1'b0;
      transfer_complete_flag <= 1'b0;
      data_invalid <= 1'b0;
      receive_data <= 8'h00;
    end else begin
      transfer_complete_flag <= 1'b0;
      if (!module_enable || slt_event) begin
        state_q <= ST_IDLE;
        ack_q <= 1'b0;
        hold_q <= 1'b0;
        ten_sel_q <= 1'b0;
        slave_transmit <= 1'b0;
        addressed_as_slave_flag <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        ten_sel_q <= 1'b0;
        ack_q <= 1'b0;
        slave_transmit <= 1'b0;
        addressed_as_slave_flag <= 1'b0;
      end else if (start_det) begin
        state_q <= ST_ADDR;
        bit_q <= 4'hF;
        ack_q <= 1'b0;
        tx_nack_q <= 1'b0;
      end else if (hold_q) begin
        if (ack_release) begin
          hold_q <= 1'b0;
          ack_q <= ~transmit_ack_select;
        end
      end else if (scl_rise && bit_q < 4'h8) begin
        shift_q <= {shift_q[6:0], sda_q};
      end else if (scl_fall && state_q != ST_IDLE) begin
        if (bit_q == 4'h7) begin
          bit_q <= 4'h8;
          case (state_q)
            ST_ADDR: begin
              if (hdr_match && !byte_in[0]) begin
                ack_q <= 1'b1;
                data_invalid <= 1'b1;
                transfer_complete_flag <= 1'b1;
                state_q <= ST_ADDR2;
              end else if (hdr_match && byte_in[0] && ten_sel_q) begin
                ack_q <= 1'b1;
                slave_transmit <= 1'b1;
                addressed_as_slave_flag <= 1'b1;
                state_q <= ST_TX;
              end else if (m7) begin
                ack_q <= 1'b1;
                addressed_as_slave_flag <= 1'b1;
                slave_transmit <= 1'b0;
                ten_sel_q <= 1'b0;
                state_q <= ST_RX;
              end else begin
                ten_sel_q <= 1'b0;
                slave_transmit <= 1'b0;
                addressed_as_slave_flag <= 1'b0;
                state_q <= ST_IDLE;
              end
            end
            ST_ADDR2: begin
              if (low_match) begin
                ack_q <= 1'b1;
                ten_sel_q <= 1'b1;
                addressed_as_slave_flag <= 1'b1;
                data_invalid <= 1'b0;
                state_q <= ST_RX;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_RX: begin
              receive_data <= byte_in;
              if (fast_ack_enable) begin
                hold_q <= 1'b1;
                transfer_complete_flag <= 1'b1;
              end else begin
                ack_q <= 1'b1;
              end
            end
            default: begin
              ack_q <= 1'b0;
            end
          endcase
        end else if (bit_q == 4'h8) begin
          bit_q <= 4'h0;
          ack_q <= 1'b0;
          if (!(state_q == ST_RX && fast_ack_enable)) begin
            transfer_complete_flag <= 1'b1;
          end
        end else begin
          bit_q <= bit_q + 4'h1;
        end
      end else if (scl_rise && bit_q == 4'h8 && state_q == ST_TX) begin
        tx_nack_q <= sda_q;
      end
    end
  end

  // Transmit bit comes from the data byte, msb first.
  wire tx_bit = transmit_data[3'h7 - bit_q[2:0]];
  wire drive_sda_low = ack_q | (state_q == ST_TX && bit_q < 4'h8 && !tx_bit && !tx_nack_q);
  assign sda_out = 1'b0;
  assign sda_oe = drive_sda_low & ~slt_hold_q & module_enable;
  assign scl_out = 1'b0;
  assign scl_oe = hold_q & ~scl_q & ~slt_hold_q & module_enable;

  // ********************
  // Timeout counters
  // ********************

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_cnt_q <= {CW{1'b0}};
      high_cnt_q <= {CW{1'b0}};
      dlow_cnt_q <= {CW{1'b0}};
      master_extend_timeout_cnt_q <= {CW{1'b0}};
      slave_extend_timeout_cnt_q <= {CW{1'b0}};
      slt_hold_q <= 1'b0;
      bus_busy <= 1'b0;
      bus_high_timeout_flag <= 1'b0;
      data_low_timeout_flag <= 1'b0;
      clock_low_timeout_flag <= 1'b0;
      master_extend_timeout <= 1'b0;
      slave_extend_timeout <= 1'b0;
      common_interrupt_flag <= 1'b0;
      master_stop_request <= 1'b0;
    end else if (!module_enable) begin
      low_cnt_q <= {CW{1'b0}};
      high_cnt_q <= {CW{1'b0}};
      dlow_cnt_q <= {CW{1'b0}};
      slt_hold_q <= 1'b0;
      bus_busy <= 1'b0;
      master_stop_request <= 1'b0;
    end else begin
      // The low, bus-high and data-low counters restart as soon as the watched condition ends.
      if (scl_q) begin
        low_cnt_q <= {CW{1'b0}};
        slt_hold_q <= 1'b0;
      end else if (!slt_event) begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end else begin
        slt_hold_q <= 1'b1;
      end
      if (scl_q && sda_q) begin
        if (high_cnt_q < THIGH_CYC[CW-1:0]) begin
          high_cnt_q <= high_cnt_q + 1'b1;
        end
      end else begin
        high_cnt_q <= {CW{1'b0}};
      end
      // Bus-high flag follows the line state and falls by itself.
      bus_high_timeout_flag <= scl_q & sda_q & (high_cnt_q == THIGH_CYC[CW-1:0]);
      if (start_det) begin
        bus_busy <= 1'b1;
      end else if (stop_det || bus_high_timeout_flag) begin
        bus_busy <= 1'b0;
      end
      if (scl_q && !sda_q) begin
        if (dlow_cnt_q != data_low_limit) begin
          dlow_cnt_q <= dlow_cnt_q + 1'b1;
        end
      end else begin
        dlow_cnt_q <= {CW{1'b0}};
      end
      // Extension time accumulates while this end stretches the clock low.
      if (byte_edge || start_det || stop_det) begin
        master_extend_timeout_cnt_q <= {CW{1'b0}};
      end else if (master_active && master_extending && !scl_q) begin
        master_extend_timeout_cnt_q <= master_extend_timeout_cnt_q + 1'b1;
      end
      if (start_det || stop_det) begin
        slave_extend_timeout_cnt_q <= {CW{1'b0}};
      end else if (hold_q && !scl_q) begin
        slave_extend_timeout_cnt_q <= slave_extend_timeout_cnt_q + 1'b1;
      end
      // Hardware sets win over software clears.
      if (slt_event || master_extend_timeout_hit || slave_extend_timeout_hit) begin
        clock_low_timeout_flag <= 1'b1;
      end else if (flag_clear) begin
        clock_low_timeout_flag <= 1'b0;
      end
      if (master_extend_timeout_hit) begin
        master_extend_timeout <= 1'b1;
      end else if (flag_clear) begin
        master_extend_timeout <= 1'b0;
      end
      if (slave_extend_timeout_hit) begin
        slave_extend_timeout <= 1'b1;
      end else if (flag_clear) begin
        slave_extend_timeout <= 1'b0;
      end
      if (dlow_hit) begin
        data_low_timeout_flag <= 1'b1;
      end else if (flag_clear) begin
        data_low_timeout_flag <= 1'b0;
      end
      if (dlow_hit || slt_event || transfer_complete_flag || (addressed_as_slave_flag && byte_edge)) begin
        common_interrupt_flag <= 1'b1;
      end else if (flag_clear) begin
        common_interrupt_flag <= 1'b0;
      end
      if (master_active && (slt_event || master_extend_timeout_hit)) begin
        master_stop_request <= 1'b1;
      end else if (!master_active || stop_det) begin
        master_stop_request <= 1'b0;
      end
    end
  end
endmodule // iam_core
`default_nettype wire

/* iam_defs.vh */
// Constants for the two-wire slave address matcher with SMBus timeouts.
`ifndef IAM_DEFS_VH
`define IAM_DEFS_VH
// Ten-bit address header pattern, upper five bits of the first byte.
`define IAM_TENBIT_HDR 5'h1E
`define IAM_GENERAL_CALL 7'h00
`define IAM_ALERT_RESPONSE 7'h0C
// Clock-low timeout in microseconds and the module clock in MHz.
`define IAM_CLK_MHZ 50
`define IAM_TLOW_US 35000
`define IAM_TLOW_CYC (`IAM_TLOW_US * `IAM_CLK_MHZ)
// Bus-high idle time in microseconds (50 us).
`define IAM_THIGH_US 50
`define IAM_THIGH_CYC (`IAM_THIGH_US * `IAM_CLK_MHZ)
// Cumulative extension limits in microseconds.
`define IAM_MASTER_EXTEND_TIMEOUT_US 10000
`define IAM_SLAVE_EXTEND_TIMEOUT_US 25000
`define IAM_MASTER_EXTEND_TIMEOUT_CYC (`IAM_MASTER_EXTEND_TIMEOUT_US * `IAM_CLK_MHZ)
`define IAM_SLAVE_EXTEND_TIMEOUT_CYC (`IAM_SLAVE_EXTEND_TIMEOUT_US * `IAM_CLK_MHZ)
`endif

/* iam_sync.v */
// Two-flop synchroniser with edge detection on the second stage.
`default_nettype none
module iam_sync (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Line in and out
  input wire line_in,
  output reg line_q,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg prev_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      line_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= line_in;
      line_q <= meta_q;
      prev_q <= line_q;
    end
  end
  assign rise = line_q & ~prev_q;
  assign fall = ~line_q & prev_q;
endmodule // iam_sync
`default_nettype wire

/* iam_core_props.sv */
// Concurrent checks on the ports of the address matcher and timeout monitor.
`default_nettype none
module iam_core_props #(
  parameter integer THIGH_CYC = 2500
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Control
  input wire logic module_enable,
  input wire logic master_active,
  // Status
  input wire logic addressed_as_slave_flag,
  input wire logic slave_transmit,
  input wire logic transfer_complete_flag,
  input wire logic bus_high_timeout_flag,
  input wire logic data_low_timeout_flag,
  input wire logic clock_low_timeout_flag,
  input wire logic master_extend_timeout,
  input wire logic slave_extend_timeout,
  input wire logic common_interrupt_flag,
  input wire logic master_stop_request
);
  timeunit 1ns;
  timeprecision 1ns;
  // *****************************************************************
  // Idle counter and properties
  // *****************************************************************
  logic [15:0] hi_cnt_q;
  // Saturates so that a long idle bus never wraps back to a small count.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_q <= 16'h0000;
    end else if (!(scl_in && sda_in)) begin
      hi_cnt_q <= 16'h0000;
    end else if (hi_cnt_q != 16'hFFFF) begin
      hi_cnt_q <= hi_cnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  property p_quiet_off;
    !module_enable |-> !scl_oe && !sda_oe;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("Line driven while disabled");
  property p_tcf_pulse;
    transfer_complete_flag |=> !transfer_complete_flag;
  endproperty
  a_tcf_pulse: assert property (p_tcf_pulse) else $error("Transfer flag longer than a cycle");
  property p_low_release;
    $rose(clock_low_timeout_flag) && !$rose(slave_extend_timeout) |=> !scl_oe && !sda_oe;
  endproperty
  a_low_release: assert property (p_low_release) else $error("Lines held after clock-low timeout");
  property p_master_extend_timeout_clock_low_timeout_flag;
    $rose(master_extend_timeout) |-> ##[0:1] clock_low_timeout_flag;
  endproperty
  a_master_extend_timeout_clock_low_timeout_flag: assert property (p_master_extend_timeout_clock_low_timeout_flag) else $error("Extension timeout without clock-low flag");
  property p_dlow_int;
    $rose(data_low_timeout_flag) |-> ##[0:1] common_interrupt_flag;
  endproperty
  a_dlow_int: assert property (p_dlow_int) else $error("Data-low timeout without interrupt");
  property p_high_fall;
    bus_high_timeout_flag && !(scl_in && sda_in) |-> ##[1:4] !bus_high_timeout_flag;
  endproperty
  a_high_fall: assert property (p_high_fall) else $error("Bus-high flag stuck on busy bus");
  property p_high_rise;
    $rose(bus_high_timeout_flag) |-> hi_cnt_q >= THIGH_CYC;
  endproperty
  a_high_rise: assert property (p_high_rise) else $error("Bus-high flag too early");
  property p_stop_req;
    $rose(master_stop_request) |-> master_active;
  endproperty
  a_stop_req: assert property (p_stop_req) else $error("Stop request while not master");
  property p_tx_sel;
    slave_transmit |-> addressed_as_slave_flag;
  endproperty
  a_tx_sel: assert property (p_tx_sel) else $error("Transmitter while not selected");
endmodule // iam_core_props
bind iam_core iam_core_props #(.THIGH_CYC(THIGH_CYC)) iam_core_props_inst (
  .clock, .nrst, .scl_in, .sda_in, .scl_oe, .sda_oe, .module_enable, .master_active,
  .addressed_as_slave_flag, .slave_transmit, .transfer_complete_flag, .bus_high_timeout_flag,
  .data_low_timeout_flag, .clock_low_timeout_flag, .master_extend_timeout, .slave_extend_timeout, .common_interrupt_flag,
  .master_stop_request
);
`default_nettype wire

/* iam_bus.sv */
// Bus master model that pulls the two-wire lines open-drain style.
`default_nettype none
module iam_bus (
  // Clock
  input wire logic clock,
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // High pulls the line low
  output logic scl_pull,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_pull = 1'h0;
    sda_pull = 1'h0;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic set(input logic c, input logic d);
    scl_pull = c;
    sda_pull = d;
  endtask
  // Works from idle and, with the clock low, as a repeated start.
  task automatic start();
    hc(2);
    sda_pull = 1'h0;
    hc(2);
    scl_pull = 1'h0;
    hc(4);
    sda_pull = 1'h1;
    hc(4);
    scl_pull = 1'h1;
  endtask
  task automatic stop();
    hc(2);
    sda_pull = 1'h1;
    hc(2);
    scl_pull = 1'h0;
    hc(4);
    sda_pull = 1'h0;
    hc(4);
  endtask
  // The wait on a high clock lets a slave stretch the acknowledge bit.
  task automatic wbyte(input logic [7:0] b, output logic ack);
    int n;
    for (int i = 7; i >= 0; i--) begin
      hc(2);
      sda_pull = ~b[i];
      hc(2);
      scl_pull = 1'h0;
      hc(4);
      scl_pull = 1'h1;
    end
    hc(2);
    sda_pull = 1'h0;
    hc(2);
    scl_pull = 1'h0;
    n = 0;
    while (scl !== 1'h1 && n < 2000) begin
      hc(1);
      n++;
    end
    ack = ~sda;
    hc(4);
    scl_pull = 1'h1;
  endtask
endmodule // iam_bus
`default_nettype wire

/* test_iam_core.sv */
// Self-checking bench for the address matcher and timeout monitor.
`default_nettype none
module test_iam_core;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TLOW = 400;
  localparam int MASTER_EXTEND_TIMEOUT = 300;
  localparam logic [55:0] ADR = {7'h24, 7'h28, 7'h50, 7'h00, 7'h0C, 7'h30, 7'h1F, 7'h20};
  logic clock = 1'h0, nrst = 1'h0, module_enable = 1'h0, address_extension_enable = 1'h0;
  logic general_call_enable = 1'h0, alert_response_enable = 1'h0, fast_ack_enable = 1'h0;
  logic transmit_ack_select = 1'h0, ack_release = 1'h0, master_active = 1'h0, master_extending = 1'h0;
  logic flag_clear = 1'h0;
  logic second_address_enable = 1'h1, range_match_enable = 1'h1, sxf, busy;
  logic [6:0] primary_address = 7'h20;
  logic [2:0] upper_address = 3'h0;
  logic [21:0] data_low_limit = 22'h000000;
  logic m_scl, m_sda, scl, sda, scl_oe, sda_oe, aas, stx, dinv, bhf, dlf, clf, mxf, cif, msr;
  logic [7:0] rxd;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  assign scl = ~(m_scl | scl_oe);
  assign sda = ~(m_sda | sda_oe);
  always #10 clock = ~clock;
  iam_core #(.TLOW_CYC(TLOW), .THIGH_CYC(200), .MASTER_EXTEND_TIMEOUT_CYC(MASTER_EXTEND_TIMEOUT), .SLAVE_EXTEND_TIMEOUT_CYC(6)) iam_core_inst (
    .clock, .nrst, .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(), .sda_oe,
    .module_enable, .primary_address, .upper_address, .address_extension_enable, .general_call_enable,
    .alert_response_enable, .second_address_enable, .second_address(7'h50), .range_match_enable,
    .range_address(7'h28), .fast_ack_enable, .transmit_ack_select, .ack_release, .data_low_limit,
    .master_active, .master_extending, .transmit_data(8'hC3), .addressed_as_slave_flag(aas),
    .slave_transmit(stx), .transfer_complete_flag(), .data_invalid(dinv), .receive_data(rxd), .bus_busy(busy),
    .bus_high_timeout_flag(bhf), .data_low_timeout_flag(dlf), .clock_low_timeout_flag(clf),
    .master_extend_timeout(mxf), .slave_extend_timeout(sxf), .common_interrupt_flag(cif),
    .master_stop_request(msr), .flag_clear
  );
  iam_bus iam_bus_inst (.clock, .scl, .sda, .scl_pull(m_scl), .sda_pull(m_sda));
  // *****************************************************************
  // Shared tasks
  // *****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    logic a;
    iam_bus_inst.wbyte(b, a);
    check(a, e);
  endtask
  task automatic clr();
    flag_clear = 1'h1;
    cyc(1);
    flag_clear = 1'h0;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // A hung handshake ends the run here well past the expected length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    logic e;
    int n;
    cyc(12);
    nrst = 1'h1;
    cyc(3);
    check({scl_oe, sda_oe, aas, clf, dlf, bhf, cif, msr}, 8'h00);
    iam_bus_inst.start();
    send(8'h40, 1'h0);
    iam_bus_inst.stop();
    module_enable = 1'h1;
    $display("Test reset done");
    for (int p = 0; p < 3; p++) begin
      general_call_enable = (p == 0);
      alert_response_enable = (p == 1);
      second_address_enable = (p < 2);
      range_match_enable = (p < 2);
      for (int i = 0; i < 8; i++) begin
        e = (i == 0) | (i == 6) | (p < 2 && (i == 5 || i == 7)) | (i == 4 && p == 0) | (i == 3 && p == 1);
        iam_bus_inst.start();
        send({ADR[i*7 +: 7], 1'h0}, e);
        check(aas, e);
        iam_bus_inst.stop();
      end
    end
    $display("Test matching done");
    address_extension_enable = 1'h1;
    upper_address = 3'h5;
    primary_address = 7'h2B;
    iam_bus_inst.start();
    send(8'hF4, 1'h1);
    check(dinv, 1'h1);
    send(8'hAB, 1'h1);
    check(aas, 1'h1);
    iam_bus_inst.start();
    send(8'hF5, 1'h1);
    check(stx, 1'h1);
    iam_bus_inst.stop();
    iam_bus_inst.start();
    send(8'hF5, 1'h0);
    iam_bus_inst.stop();
    iam_bus_inst.start();
    send(8'hF4, 1'h1);
    send(8'hAC, 1'h0);
    iam_bus_inst.stop();
    address_extension_enable = 1'h0;
    primary_address = 7'h20;
    $display("Test ten-bit done");
    fast_ack_enable = 1'h1;
    transmit_ack_select = 1'h1;
    iam_bus_inst.start();
    send(8'h40, 1'h1);
    fork
      send(8'h5A, 1'h0);
      begin
        n = 0;
        while (scl_oe !== 1'h1 && n < 200) begin
          cyc(1);
          n++;
        end
        cyc(8);
        check({scl_oe, scl}, 2'h2);
        ack_release = 1'h1;
        cyc(1);
        ack_release = 1'h0;
      end
    join
    check(rxd, 8'h5A);
    check({sxf, clf}, 2'h3);
    iam_bus_inst.stop();
    fast_ack_enable = 1'h0;
    clr();
    $display("Test fast acknowledge done");
    iam_bus_inst.start();
    send(8'h40, 1'h1);
    iam_bus_inst.set(1'h1, 1'h0);
    cyc(TLOW + 50);
    check({clf, scl_oe, sda_oe, aas}, 4'h8);
    iam_bus_inst.set(1'h0, 1'h0);
    iam_bus_inst.start();
    send(8'h40, 1'h1);
    iam_bus_inst.stop();
    clr();
    master_active = 1'h1;
    master_extending = 1'h1;
    iam_bus_inst.start();
    cyc(MASTER_EXTEND_TIMEOUT + 50);
    check({mxf, clf}, 2'h3);
    cyc(100);
    check(msr, 1'h1);
    master_extending = 1'h0;
    iam_bus_inst.stop();
    master_active = 1'h0;
    clr();
    $display("Test clock-low done");
    data_low_limit = 22'h000064;
    iam_bus_inst.set(1'h0, 1'h1);
    cyc(150);
    check({dlf, cif, busy}, 3'h7);
    iam_bus_inst.set(1'h1, 1'h1);
    cyc(2);
    iam_bus_inst.set(1'h1, 1'h0);
    cyc(2);
    iam_bus_inst.set(1'h0, 1'h0);
    cyc(4);
    check({bhf, busy}, 2'h1);
    cyc(220);
    check({bhf, busy}, 2'h2);
    iam_bus_inst.start();
    check(bhf, 1'h0);
    iam_bus_inst.stop();
    $display("Test bus timeouts done");
    print_verdict();
  end
endmodule // test_iam_core
`default_nettype wire
